// File: include/pia_defines.vh
// Constants for the prioritized interrupt arbiter: register offsets,
// field layout, reset values and source map.
// Assumes inclusion by bare name from logic files.
`ifndef PIA_DEFINES_VH
`define PIA_DEFINES_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PIA_NSRC        82
`define PIA_VNUM_W      7
`define PIA_ADDR_W      21
`define PIA_LVL_REGS    11
`define PIA_EN_REGS     6

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define PIA_OFF_VBASE   6'h0A
`define PIA_OFF_FM0     6'h0B
`define PIA_OFF_FVL0    6'h0C
`define PIA_OFF_FVH0    6'h0D
`define PIA_OFF_FM1     6'h0E
`define PIA_OFF_FVL1    6'h0F
`define PIA_OFF_FVH1    6'h10
`define PIA_OFF_PEND    6'h11
`define PIA_OFF_CTRL    6'h1D
`define PIA_OFF_EVST    6'h1E
`define PIA_OFF_EVMSK   6'h1F
`define PIA_OFF_LVL     6'h20
`define PIA_OFF_EN      6'h30

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PIA_CTRL_EDGE_A 0
`define PIA_CTRL_EDGE_B 1
`define PIA_CTRL_LVL_LO 2
`define PIA_CTRL_REQ    4

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define PIA_EV_FAST     0
`define PIA_EV_WAKE     1
`define PIA_EV_ACK      2
`define PIA_EV_W        3

// ----------------------------------------------------------------
// Source map and reset values
// ----------------------------------------------------------------
`define PIA_SRC_EXT_A   7'h02
`define PIA_SRC_EXT_B   7'h03
`define PIA_FIXED_MASK  82'h0_0000_0000_0000_0000_0003
`define PIA_FIXED_LVL   2'h3
`define PIA_RESET_VEC   21'h0_0000
`define PIA_VBASE_RST   16'h0000
`define PIA_FM_RST      7'h7F

`endif

// File: logic/pia_arbiter.v
// Interrupt arbiter: level assignment, per-level lowest-number pick,
// nesting by current level, fast vector slots and low-power wake.
// Assumes sources and core signals on ref_clk; external irq pins async.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pia_defines.vh"

// Summary of operation
// - registers reached over simple slave port
// - each source gets one of four levels
// - within level, lowest source number wins
// - request core, supply jump address
// - normal vector is base joined with number
// - level code tracks serviced level, nesting
// - fast only if match and level 2
// - fast uses slot low/high address
// - fast class settled with vector
// - wake request in low-power modes
// - reset vector driven after reset
// - only pre-enabled sources may wake
// - external irqs level-sensitive in low power
module pia_arbiter (
  // Clock, reset, enable
  input  wire                      ref_clk,
  input  wire                      rstn,
  input  wire                      clk_en,
  // Register port
  input  wire [5:0]                reg_addr,
  input  wire [15:0]               reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [15:0]               reg_rdata,
  // Interrupt sources
  input  wire [`PIA_NSRC-1:0]      irq_src,
  input  wire                      external_irq_a_n,
  input  wire                      external_irq_b_n,
  // Core side
  input  wire                      core_ack,
  input  wire                      core_ret,
  input  wire [1:0]                core_ret_level,
  output reg                       irq_req,
  output reg  [`PIA_ADDR_W-1:0]    vec_addr,
  output reg  [`PIA_VNUM_W-1:0]    vec_num,
  output reg                       vec_fast,
  output reg  [1:0]                current_level_code,
  output reg                       reset_fetch,
  // Low power
  input  wire                      low_power_mode,
  output reg                       wake_req,
  // Block interrupt
  output wire                      irq_out
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [`PIA_VNUM_W-1:0] lowest_idx;
    input [`PIA_NSRC-1:0] v;
    integer k;
    begin
      lowest_idx = {`PIA_VNUM_W{1'b0}};
      for (k = `PIA_NSRC-1; k >= 0; k = k - 1)
        if (v[k])
          lowest_idx = k[`PIA_VNUM_W-1:0];
    end
  endfunction

  function [1:0] eff_level;
    input [2*`PIA_NSRC-1:0] lv;
    input integer           i;
    reg   [`PIA_NSRC-1:0]   fx;
    begin
      fx = `PIA_FIXED_MASK;
      eff_level = fx[i] ? `PIA_FIXED_LVL : lv[2*i +: 2];
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [2*`PIA_NSRC-1:0]    lvl_r;
  reg [`PIA_NSRC-1:0]      en_r;
  reg [`PIA_NSRC-1:0]      en_snap_r;
  reg [15:0]               vbase_r;
  reg [`PIA_VNUM_W-1:0]    fm0_r;
  reg [`PIA_VNUM_W-1:0]    fm1_r;
  reg [15:0]               fvl0_r;
  reg [15:0]               fvl1_r;
  reg [4:0]                fvh0_r;
  reg [4:0]                fvh1_r;
  reg [1:0]                edge_mode_r;
  reg [`PIA_EV_W-1:0]      ev_st_r;
  reg [`PIA_EV_W-1:0]      ev_msk_r;
  reg [1:0]                ext_s1_r;
  reg [1:0]                ext_s2_r;
  reg [1:0]                ext_prev_r;
  reg [1:0]                ext_edge_r;
  reg                      lp_prev_r;

  // ----------------------------------------------------------------
  // External pins: two-flop sync, edge or level
  // ----------------------------------------------------------------
  wire [1:0] ext_low  = ~ext_s2_r;
  wire [1:0] ext_fall = ext_prev_r & ~ext_s2_r;
  // No edge can be seen with clocks stopped, so low power forces level
  wire [1:0] ext_req;
  assign ext_req[0] = (edge_mode_r[0] && !low_power_mode) ? ext_edge_r[0] : ext_low[0];
  assign ext_req[1] = (edge_mode_r[1] && !low_power_mode) ? ext_edge_r[1] : ext_low[1];

  reg [`PIA_NSRC-1:0] src_eff;
  always @*
  begin
    src_eff = irq_src;
    src_eff[`PIA_SRC_EXT_A] = ext_req[0];
    src_eff[`PIA_SRC_EXT_B] = ext_req[1];
  end

  // Fixed sources count as always enabled
  wire [`PIA_NSRC-1:0] en_eff = en_r | `PIA_FIXED_MASK;
  wire [`PIA_NSRC-1:0] pend   = src_eff & en_eff;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  reg [`PIA_NSRC-1:0]   act0;
  reg [`PIA_NSRC-1:0]   act1;
  reg [`PIA_NSRC-1:0]   act2;
  reg [`PIA_NSRC-1:0]   act3;
  integer               s;
  always @*
  begin
    act0 = {`PIA_NSRC{1'b0}};
    act1 = {`PIA_NSRC{1'b0}};
    act2 = {`PIA_NSRC{1'b0}};
    act3 = {`PIA_NSRC{1'b0}};
    for (s = 0; s < `PIA_NSRC; s = s + 1)
    begin
      case (eff_level(lvl_r, s))
        2'd0:    act0[s] = pend[s];
        2'd1:    act1[s] = pend[s];
        2'd2:    act2[s] = pend[s];
        default: act3[s] = pend[s];
      endcase
    end
  end

  // Nesting: level must reach the current level code
  wire                   ok3     = |act3;
  wire                   ok2     = |act2 && current_level_code <= 2'd2;
  wire                   ok1     = |act1 && current_level_code <= 2'd1;
  wire                   ok0     = |act0 && current_level_code == 2'd0;
  wire                   win_any = ok3 || ok2 || ok1 || ok0;
  wire [1:0]             win_lvl = ok3 ? 2'd3 : ok2 ? 2'd2 : ok1 ? 2'd1 : 2'd0;
  // Number is only used where win_any or a level-2 win qualifies it
  wire [`PIA_VNUM_W-1:0] win_num = lowest_idx(ok3 ? act3 : ok2 ? act2 : ok1 ? act1 : act0);

  // Fast class decided here, same cycle as the vector
  wire hit0     = (win_num == fm0_r) && (win_lvl == 2'd2);
  wire hit1     = (win_num == fm1_r) && (win_lvl == 2'd2);
  wire win_fast = hit0 || hit1;
  wire [`PIA_ADDR_W-1:0] win_addr =
    hit0 ? {fvh0_r, fvl0_r} :
    hit1 ? {fvh1_r, fvl1_r} :
    {vbase_r[13:0], win_num};

  // Level code for the serviced level: 2 and 3 share a code
  wire [1:0] ack_code = (win_lvl == 2'd0) ? 2'd1 :
                        (win_lvl == 2'd1) ? 2'd2 : 2'd3;

  // ----------------------------------------------------------------
  // Wake: only sources enabled before entry
  // ----------------------------------------------------------------
  wire lp_entry = low_power_mode && !lp_prev_r;
  wire wake_nxt = low_power_mode && |(src_eff & en_eff & en_snap_r);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  wire [5:0] lvl_idx = reg_addr - `PIA_OFF_LVL;
  wire [5:0] en_idx  = reg_addr - `PIA_OFF_EN;
  wire lvl_hit = reg_addr >= `PIA_OFF_LVL && lvl_idx < `PIA_LVL_REGS;
  wire en_hit  = reg_addr >= `PIA_OFF_EN  && en_idx  < `PIA_EN_REGS;
  wire [5:0] pend_idx = reg_addr - `PIA_OFF_PEND;
  wire pend_hit = reg_addr >= `PIA_OFF_PEND && pend_idx < `PIA_EN_REGS;

  wire [`PIA_EV_W-1:0] ev_set;
  assign ev_set[`PIA_EV_FAST] = core_ack && win_any && win_fast;
  assign ev_set[`PIA_EV_WAKE] = wake_nxt && !wake_req;
  assign ev_set[`PIA_EV_ACK]  = core_ack && win_any;

  wire [`PIA_EV_W-1:0] ev_clr =
    (reg_wr && reg_addr == `PIA_OFF_EVST) ? reg_wdata[`PIA_EV_W-1:0] : {`PIA_EV_W{1'b0}};

  // Acked external edge latch is consumed
  wire [1:0] ext_take;
  assign ext_take[0] = core_ack && win_any && win_num == `PIA_SRC_EXT_A;
  assign ext_take[1] = core_ack && win_any && win_num == `PIA_SRC_EXT_B;

  integer f;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lvl_r       <= {2*`PIA_NSRC{1'b0}};
      en_r        <= {`PIA_NSRC{1'b0}};
      en_snap_r   <= {`PIA_NSRC{1'b0}};
      vbase_r     <= `PIA_VBASE_RST;
      fm0_r       <= `PIA_FM_RST;
      fm1_r       <= `PIA_FM_RST;
      fvl0_r      <= 16'h0000;
      fvl1_r      <= 16'h0000;
      fvh0_r      <= 5'h00;
      fvh1_r      <= 5'h00;
      edge_mode_r <= 2'h0;
      ev_st_r     <= {`PIA_EV_W{1'b0}};
      ev_msk_r    <= {`PIA_EV_W{1'b0}};
      lp_prev_r   <= 1'b0;
    end
    else if (clk_en)
    begin
      lp_prev_r <= low_power_mode;
      if (lp_entry)
        en_snap_r <= en_eff;
      // Set beats a same-cycle clear
      ev_st_r <= (ev_st_r & ~ev_clr) | ev_set;
      if (reg_wr)
      begin
        case (reg_addr)
          `PIA_OFF_VBASE: vbase_r     <= reg_wdata;
          `PIA_OFF_FM0:   fm0_r       <= reg_wdata[`PIA_VNUM_W-1:0];
          `PIA_OFF_FVL0:  fvl0_r      <= reg_wdata;
          `PIA_OFF_FVH0:  fvh0_r      <= reg_wdata[4:0];
          `PIA_OFF_FM1:   fm1_r       <= reg_wdata[`PIA_VNUM_W-1:0];
          `PIA_OFF_FVL1:  fvl1_r      <= reg_wdata;
          `PIA_OFF_FVH1:  fvh1_r      <= reg_wdata[4:0];
          `PIA_OFF_CTRL:  edge_mode_r <= reg_wdata[1:0];
          `PIA_OFF_EVMSK: ev_msk_r    <= reg_wdata[`PIA_EV_W-1:0];
          default:
          begin
            for (f = 0; f < 8; f = f + 1)
            begin
              if (lvl_hit && lvl_idx * 8 + f < `PIA_NSRC)
                lvl_r[2*(lvl_idx*8+f) +: 2] <= reg_wdata[2*f +: 2];
            end
            for (f = 0; f < 16; f = f + 1)
            begin
              if (en_hit && en_idx * 16 + f < `PIA_NSRC)
                en_r[en_idx*16+f] <= reg_wdata[f];
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin sync and edge latches
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_s1_r   <= 2'h3;
      ext_s2_r   <= 2'h3;
      ext_prev_r <= 2'h3;
      ext_edge_r <= 2'h0;
    end
    else if (clk_en)
    begin
      ext_s1_r   <= {external_irq_b_n, external_irq_a_n};
      ext_s2_r   <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      ext_edge_r <= (ext_edge_r & ~ext_take) | ext_fall;
    end
  end

  // ----------------------------------------------------------------
  // Core interface
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_req            <= 1'b0;
      vec_addr           <= `PIA_RESET_VEC;
      vec_num            <= {`PIA_VNUM_W{1'b0}};
      vec_fast           <= 1'b0;
      current_level_code <= 2'd0;
      reset_fetch        <= 1'b1;
      wake_req           <= 1'b0;
    end
    else if (clk_en)
    begin
      reset_fetch <= 1'b0;
      wake_req    <= wake_nxt;
      irq_req     <= win_any;
      vec_num     <= win_any ? win_num : {`PIA_VNUM_W{1'b0}};
      vec_addr    <= win_any ? win_addr : {`PIA_ADDR_W{1'b0}};
      vec_fast    <= win_any && win_fast;
      if (core_ack && win_any)
        current_level_code <= ack_code;
      else if (core_ret)
        current_level_code <= core_ret_level;
    end
  end

  assign irq_out = |(ev_st_r & ev_msk_r);

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  reg [15:0] rd_nxt;
  integer    r;
  always @*
  begin
    rd_nxt = 16'h0000;
    case (reg_addr)
      `PIA_OFF_VBASE: rd_nxt = vbase_r;
      `PIA_OFF_FM0:   rd_nxt = {9'h000, fm0_r};
      `PIA_OFF_FVL0:  rd_nxt = fvl0_r;
      `PIA_OFF_FVH0:  rd_nxt = {11'h000, fvh0_r};
      `PIA_OFF_FM1:   rd_nxt = {9'h000, fm1_r};
      `PIA_OFF_FVL1:  rd_nxt = fvl1_r;
      `PIA_OFF_FVH1:  rd_nxt = {11'h000, fvh1_r};
      `PIA_OFF_CTRL:  rd_nxt = {11'h000, irq_req, current_level_code, edge_mode_r};
      `PIA_OFF_EVST:  rd_nxt = {13'h0000, ev_st_r};
      `PIA_OFF_EVMSK: rd_nxt = {13'h0000, ev_msk_r};
      default:
      begin
        for (r = 0; r < 16; r = r + 1)
        begin
          if (pend_hit && pend_idx * 16 + r < `PIA_NSRC)
            rd_nxt[r] = pend[pend_idx * 16 + r];
          if (en_hit && en_idx * 16 + r < `PIA_NSRC)
            rd_nxt[r] = en_r[en_idx * 16 + r];
        end
        for (r = 0; r < 8; r = r + 1)
          if (lvl_hit && lvl_idx * 8 + r < `PIA_NSRC)
            rd_nxt[2*r +: 2] = eff_level(lvl_r, lvl_idx * 8 + r);
      end
    endcase
  end

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_nxt : 16'h0000;
  end

endmodule // pia_arbiter
`default_nettype wire

// File: sim/pia_arbiter_assertions.sv
// Port checker for the interrupt arbiter.
// Assumes one clock domain and the register port of the arbiter.
`timescale 1ns/1ps
`default_nettype none
`include "pia_defines.vh"
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module pia_arbiter_chk (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   clk_en,
  // Register port
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            reg_rdata,
  // Core side
  input  wire logic                   core_ack,
  input  wire logic                   core_ret,
  input  wire logic [1:0]             core_ret_level,
  input  wire logic                   irq_req,
  input  wire logic [`PIA_ADDR_W-1:0] vec_addr,
  input  wire logic [`PIA_VNUM_W-1:0] vec_num,
  input  wire logic                   vec_fast,
  input  wire logic [1:0]             current_level_code,
  input  wire logic                   reset_fetch,
  // Low power
  input  wire logic                   low_power_mode,
  input  wire logic                   wake_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_take;
    clk_en && core_ack && irq_req && !core_ret;
  endsequence
  sequence s_return;
    clk_en && core_ret && !core_ack;
  endsequence
  a_read_idle_zero: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  a_no_req_vec: assert property (!irq_req |-> vec_addr == 21'h00_0000)
    else $error("vector shown without request");
  a_normal_addr: assert property (irq_req && !vec_fast |-> vec_addr[6:0] == vec_num)
    else $error("normal vector does not end in number");
  a_fast_eligible: assert property (vec_fast && $past(clk_en) |-> irq_req && $past(current_level_code) != 2'h3)
    else $error("fast vector while ineligible");
  a_reset_fetch_vec: assert property (reset_fetch |-> vec_addr == `PIA_RESET_VEC && !irq_req)
    else $error("reset vector not driven");
  a_ack_raises_level: assert property (s_take |=> current_level_code != 2'h0)
    else $error("level code not raised after take");
  a_ret_restores: assert property (s_return |=> current_level_code == $past(core_ret_level))
    else $error("level code not restored on return");
  a_wake_in_mode: assert property (wake_req && $past(clk_en) |-> $past(low_power_mode))
    else $error("wake request outside low power");
endmodule // pia_arbiter_chk

bind pia_arbiter pia_arbiter_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .core_ack(core_ack), .core_ret(core_ret), .core_ret_level(core_ret_level),
  .irq_req(irq_req), .vec_addr(vec_addr), .vec_num(vec_num), .vec_fast(vec_fast),
  .current_level_code(current_level_code), .reset_fetch(reset_fetch), .low_power_mode(low_power_mode),
  .wake_req(wake_req));
`default_nettype wire

// File: sim/pia_core_model.sv
// Core model: takes the presented vector on command and returns.
// Assumes the bench tells it the winner level and its mask bits.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Core model
// ----------------------------------------------------------------
module pia_core_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Arbiter side
  input  wire logic       irq_req,
  output logic            core_ack,
  output logic            core_ret,
  output logic [1:0]      core_ret_level,
  // Bench commands
  input  wire logic       take,
  input  wire logic       ret_go,
  input  wire logic [1:0] ret_lvl,
  input  wire logic [1:0] mask_bits,
  input  wire logic [1:0] win_lvl
);
  always @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      core_ack       <= 1'b0;
      core_ret       <= 1'b0;
      core_ret_level <= 2'h0;
    end
    else
    begin
      core_ack       <= take && irq_req && (win_lvl >= mask_bits);
      core_ret       <= ret_go;
      // Garbage outside a return so a sloppy load shows up
      core_ret_level <= ret_go ? ret_lvl : ~ret_lvl;
    end
endmodule // pia_core_model
`default_nettype wire

// File: sim/prioritized_interrupt_arbiter_tb.sv
// Self-checking bench for the interrupt arbiter.
// Assumes the arbiter, its checker and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pia_defines.vh"
module prioritized_interrupt_arbiter_tb;
  logic        ref_clk, rstn, clk_en, reg_wr, reg_rd, ext_a_n, ext_b_n, low_power_mode, take, ret_go;
  logic        core_ack, core_ret, irq_req, vec_fast, reset_fetch, wake_req, irq_out;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [81:0] irq_src;
  logic [1:0]  ret_lvl, mask_bits, win_lvl, current_level_code, core_ret_level;
  logic [20:0] vec_addr;
  logic [6:0]  vec_num;
  logic [15:0] lvl_sh [11];
  logic [15:0] en_sh [6];
  int          n_errors, check_count;

  pia_arbiter i_dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_src(irq_src),
    .external_irq_a_n(ext_a_n), .external_irq_b_n(ext_b_n), .core_ack(core_ack), .core_ret(core_ret),
    .core_ret_level(core_ret_level), .irq_req(irq_req), .vec_addr(vec_addr), .vec_num(vec_num),
    .vec_fast(vec_fast), .current_level_code(current_level_code), .reset_fetch(reset_fetch),
    .low_power_mode(low_power_mode), .wake_req(wake_req), .irq_out(irq_out));
  pia_core_model i_core (.ref_clk(ref_clk), .rstn(rstn), .irq_req(irq_req), .core_ack(core_ack),
    .core_ret(core_ret), .core_ret_level(core_ret_level), .take(take), .ret_go(ret_go),
    .ret_lvl(ret_lvl), .mask_bits(mask_bits), .win_lvl(win_lvl));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Shadow copies keep neighbouring fields intact on whole-word writes
  task automatic cfg(input int i, input logic [1:0] l);
    lvl_sh[i/8][2*(i%8)+:2] = l;
    en_sh[i/16][i%16] = 1'b1;
    wr(`PIA_OFF_LVL + 6'(i/8), lvl_sh[i/8]);
    wr(`PIA_OFF_EN + 6'(i/16), en_sh[i/16]);
  endtask
  task automatic src(input int i, input logic v);
    @(posedge ref_clk);
    irq_src[i] <= v;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #(4000 * 50);
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {rstn, reg_wr, reg_rd, low_power_mode, take, ret_go} = '0;
    {clk_en, ext_a_n, ext_b_n} = 3'b111;
    {reg_addr, reg_wdata, irq_src, ret_lvl, mask_bits, win_lvl} = '0;
    foreach (lvl_sh[k]) lvl_sh[k] = 16'h0000;
    foreach (en_sh[k]) en_sh[k] = 16'h0000;
    n_errors = 0;
    check_count = 0;
    repeat (4) @(posedge ref_clk);
    #1 chk("reset_fetch", 1, reset_fetch);
    chk("reset vector", `PIA_RESET_VEC, vec_addr);
    @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`PIA_OFF_FM0);
    chk("match slot reset", 16'h007F, d);
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F);
    chk("unmapped read", 16'h0000, d);
    wr(`PIA_OFF_VBASE, 16'h1234);
    rd(`PIA_OFF_VBASE);
    chk("vector base", 16'h1234, d);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`PIA_OFF_VBASE, 16'h5678);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(`PIA_OFF_VBASE);
    chk("frozen write", 16'h1234, d);
    wr(`PIA_OFF_LVL, 16'h0000);
    rd(`PIA_OFF_LVL);
    chk("fixed levels", 4'hF, d[3:0]);
    cfg(7, 2'h1);
    cfg(5, 2'h1);
    cfg(40, 2'h2);
    @(posedge ref_clk);
    irq_src[7] <= 1'b1;
    irq_src[5] <= 1'b1;
    step(1);
    chk("request", 1, irq_req);
    chk("same level winner", 5, vec_num);
    chk("normal vector", {14'h1234, 7'd5}, vec_addr);
    src(40, 1'b1);
    step(1);
    chk("higher level winner", 40, vec_num);
    win_lvl = 2'h2;
    @(posedge ref_clk);
    take <= 1'b1;
    @(posedge ref_clk);
    take <= 1'b0;
    step(2);
    chk("level code after take", 2'h3, current_level_code);
    chk("nested lower blocked", 0, irq_req);
    src(40, 1'b0);
    @(posedge ref_clk);
    ret_go  <= 1'b1;
    ret_lvl <= 2'h0;
    @(posedge ref_clk);
    ret_go <= 1'b0;
    step(2);
    chk("level code restored", 2'h0, current_level_code);
    chk("pending again", 5, vec_num);
    @(posedge ref_clk);
    irq_src[5] <= 1'b0;
    irq_src[7] <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      wr(`PIA_OFF_FM0 + 6'(3 * (1 - s)), 16'h007F);
      wr(`PIA_OFF_FM0 + 6'(3 * s), 16'h0028);
      wr(`PIA_OFF_FVL0 + 6'(3 * s), 16'hBEE0 + 16'(s));
      wr(`PIA_OFF_FVH0 + 6'(3 * s), 16'h0015);
      src(40, 1'b1);
      step(1);
      chk("fast flag", 1, vec_fast);
      chk("fast vector", {5'h15, 16'hBEE0 + 16'(s)}, vec_addr);
      src(40, 1'b0);
    end
    cfg(40, 2'h1);
    src(40, 1'b1);
    step(1);
    chk("match off level 2", 0, vec_fast);
    chk("normal vector", {14'h1234, 7'd40}, vec_addr);
    src(40, 1'b0);
    src(60, 1'b1);
    step(1);
    chk("disabled ignored", 0, irq_req);
    chk("no vector", 0, vec_addr);
    src(60, 1'b0);
    wr(`PIA_OFF_EVST, 16'h0007);
    cfg(2, 2'h0);
    wr(`PIA_OFF_CTRL, 16'h0001);
    wr(`PIA_OFF_EVMSK, 16'h0002);
    @(posedge ref_clk);
    low_power_mode <= 1'b1;
    cfg(11, 2'h0);
    src(11, 1'b1);
    step(4);
    chk("late enable no wake", 0, wake_req);
    @(posedge ref_clk);
    ext_a_n <= 1'b0;
    step(6);
    chk("pin wake", 1, wake_req);
    chk("event interrupt", 1, irq_out);
    wr(`PIA_OFF_EVMSK, 16'h0000);
    #1 chk("masked interrupt", 0, irq_out);
    wr(`PIA_OFF_EVMSK, 16'h0002);
    wr(`PIA_OFF_EVST, 16'h0002);
    #1 chk("cleared interrupt", 0, irq_out);
    @(posedge ref_clk);
    ext_a_n        <= 1'b1;
    low_power_mode <= 1'b0;
    irq_src[11]    <= 1'b0;
    step(4);
    print_verdict();
  end
endmodule // prioritized_interrupt_arbiter_tb
`default_nettype wire
